/* File: rtl/umf_pkg.sv */
package umf_pkg;
	// register indices on the plain register port
	localparam logic [3:0] ADDR_MODEM_STATUS  = 4'h0;
	localparam logic [3:0] ADDR_SCRATCH       = 4'h1;
	localparam logic [3:0] ADDR_DIV_LOW       = 4'h2;
	localparam logic [3:0] ADDR_DIV_HIGH      = 4'h3;
	localparam logic [3:0] ADDR_PART_ID       = 4'h4;
	localparam logic [3:0] ADDR_PART_REV      = 4'h5;
	localparam logic [3:0] ADDR_ENH_FEATURE   = 4'h6;
	localparam logic [3:0] ADDR_MODEM_CONTROL = 4'h7;
	localparam logic [3:0] ADDR_INT_ENABLE    = 4'h8;
	localparam logic [3:0] ADDR_INT_STATUS    = 4'h9;
	localparam logic [3:0] ADDR_FIFO_CONTROL  = 4'ha;
	localparam logic [3:0] ADDR_STOP_CHAR2    = 4'hb;
	localparam logic [3:0] ADDR_RX_TRIGGER    = 4'hc;
	// reset values
	localparam logic [7:0]  SCRATCH_RESET = 8'hff;
	localparam logic [15:0] DIVISOR_RESET = 16'h0001;
	localparam logic [7:0]  PART_ID_VALUE  = 8'h5a; // arbitrary value
	localparam logic [7:0]  PART_REV_VALUE = 8'h3c; // arbitrary value
	localparam logic [4:0]  RX_TRIGGER_RESET = 5'h08;
	// field positions
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam int EF_ENH = 4;
	localparam int EF_SPECIAL = 5;
	localparam int EF_AUTO_RTS = 6;
	localparam int EF_AUTO_CTS = 7;
	localparam int IE_MODEM = 3;
	localparam int IE_SPECIAL = 5;
	// gated enhanced bit masks
	localparam logic [7:0] MASK_IE_ENH = 8'hf0;
	localparam logic [7:0] MASK_IS_ENH = 8'h30;
	localparam logic [7:0] MASK_FC_ENH = 8'h30;
	localparam logic [7:0] MASK_MC_ENH = 8'he4;
	// prescaled oversampling
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [1:0] PRESCALE_LAST   = 2'h3;
	// modem pins, active low at the pins
	typedef struct packed {
		logic ctsN;
		logic dsrN;
		logic riN;
		logic cdN;
	} umf_modem_in_t;
	// transmit flow and receive compare selection
	typedef enum {TXF_NONE, TXF_PAIR1, TXF_PAIR2, TXF_BOTH} umf_txflow_t;
	typedef enum {RXF_NONE, RXF_PAIR1, RXF_PAIR2, RXF_EITHER, RXF_SEQUENCE} umf_rxflow_t;
endpackage

/* File: rtl/umf_uart_modem.sv */
// What this block does
// - ring delta flag on ring pin rising
// - carrier delta flag on any carrier change
// - auto CTS pauses transmit after current character
// - CTS status is inverted pin, loopback RTS
// - DSR status is inverted pin, loopback DTR
// - ring status inverted pin, loopback control bit2
// - carrier status inverted pin, loopback bit3
// - scratch byte read/write, resets to ff
// - baud tick is clock/16/divisor, or clock/64/divisor with control bit7 set
// - read-only part identification register
// - read-only part revision register
// - decode transmit flow selection bits
// - decode receive compare bits
// - dual mode pairs two characters as sequence
// - enhanced enable gates writes to enhanced bits
// - reset clears all gated enhanced bits
// - special character match sets status bit4
// - pair2 compare drops match, raises interrupts
// - auto RTS deasserts above trigger, reasserts below
// - RTS follows control bit when auto off
// - loopback bit routes control to status inputs
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module umf_uart_modem
	import umf_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// register port
	input  wire logic [3:0]        regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [7:0]        regRdata,
	// modem pins
	input  wire umf_pkg::umf_modem_in_t modemPins,
	output logic                   rtsN,
	output logic                   dtrN,
	// transmitter and receiver side
	input  wire logic              txCharDone,
	output logic                   txAllowed,
	input  wire logic              rxValid,
	input  wire logic [7:0]        rxChar,
	input  wire logic [4:0]        rxFill,
	output logic                   rxStore,
	output logic                   baudTick,
	output logic                   modemIrq,
	output logic                   specialIrq,
	output logic                   stopCharIrq,
	output logic                   rxTriggerIrq,
	output logic                   txSendPair2
);
	import umf_pkg::*;

	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  scratch_q;        // general purpose byte
	logic [15:0] divisor_q;        // baud divisor
	logic [7:0]  efr_q;            // enhanced feature control
	logic [7:0]  mcr_q;            // modem control
	logic [7:0]  ier_q;            // interrupt enable
	logic [7:0]  isr_q;            // writable interrupt status bits
	logic [7:0]  fcr_q;            // fifo control
	logic [7:0]  stop2_q;          // second stop character
	logic [4:0]  rxTrig_q;         // receive trigger level
	logic [3:0]  delta_q;          // modem status delta flags
	logic [3:0]  sync1_q;          // first synchroniser stage
	logic [3:0]  sync2_q;          // second synchroniser stage
	logic [3:0]  prev_q;           // previous effective status
	logic [3:0]  stat;             // effective active-high status
	logic        rtsHold_q;        // auto RTS throttle
	logic        txPause_q;        // auto CTS pause latch
	logic        seqHalf_q;        // first char of sequence seen
	logic [1:0]  pre_q;            // clock prescaler
	logic [3:0]  over_q;           // x16 oversampling counter
	logic [15:0] baudCnt_q;        // divisor counter
	umf_txflow_t txFlow;           // decoded transmit flow
	umf_rxflow_t rxFlow;           // decoded receive compare
	logic        specialHit;       // received char equals second stop char
	logic        dropMatch;        // matched in pair2 compare mode

	// merge a write into a register, enhanced bits only when allowed
	function automatic logic [7:0] gatedWrite(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask, input logic en);
		logic [7:0] keep;
		keep = en ? 8'h00 : mask;
		return (old & keep) | (wd & ~keep);
	endfunction

	////////////////////////////////////////////////////////////////
	// modem pin synchroniser, two flops before any use
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
		end else begin
			sync1_q <= {modemPins.ctsN, modemPins.dsrN, modemPins.riN, modemPins.cdN};
			sync2_q <= sync1_q;
		end
	end

	// status: inverted pins, or control bits in loopback
	always_comb begin
		if (mcr_q[MC_LOOP]) begin
			stat = {mcr_q[MC_RTS], mcr_q[MC_DTR], mcr_q[MC_OUT1], mcr_q[MC_OUT2]};
		end else begin
			stat = ~sync2_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// delta flags; a new change beats the read clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q  <= 4'h0;
			delta_q <= 4'h0;
		end else begin
			prev_q <= stat;
			delta_q <= (regRd && regAddr == ADDR_MODEM_STATUS) ? 4'h0 : delta_q;
			if (stat[3] != prev_q[3]) delta_q[0] <= 1'b1;
			if (stat[2] != prev_q[2]) delta_q[1] <= 1'b1;
			// ring status high means pin low: end of ring is status falling
			if (prev_q[1] && !stat[1]) delta_q[2] <= 1'b1;
			if (stat[0] != prev_q[0]) delta_q[3] <= 1'b1;
		end
	end

	// modem interrupt output
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) modemIrq <= 1'b0;
		else modemIrq <= ier_q[IE_MODEM] && (delta_q != 4'h0);
	end

	////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scratch_q <= SCRATCH_RESET;
			divisor_q <= DIVISOR_RESET;
			efr_q <= 8'h00;
			mcr_q <= 8'h00;
			ier_q <= 8'h00;
			fcr_q <= 8'h00;
			stop2_q <= 8'h00;
			rxTrig_q <= RX_TRIGGER_RESET;
		end else if (regWr) begin
			if (regAddr == ADDR_SCRATCH) begin
				scratch_q <= regWdata;
			end else if (regAddr == ADDR_DIV_LOW) begin
				divisor_q[7:0] <= regWdata;
			end else if (regAddr == ADDR_DIV_HIGH) begin
				divisor_q[15:8] <= regWdata;
			end else if (regAddr == ADDR_ENH_FEATURE) begin
				efr_q <= regWdata;
			end else if (regAddr == ADDR_MODEM_CONTROL) begin
				mcr_q <= gatedWrite(mcr_q, regWdata, MASK_MC_ENH, efr_q[EF_ENH]);
			end else if (regAddr == ADDR_INT_ENABLE) begin
				ier_q <= gatedWrite(ier_q, regWdata, MASK_IE_ENH, efr_q[EF_ENH]);
			end else if (regAddr == ADDR_FIFO_CONTROL) begin
				fcr_q <= gatedWrite(fcr_q, regWdata, MASK_FC_ENH, efr_q[EF_ENH]);
			end else if (regAddr == ADDR_STOP_CHAR2) begin
				stop2_q <= regWdata;
			end else if (regAddr == ADDR_RX_TRIGGER) begin
				rxTrig_q <= regWdata[4:0];
			end
		end
	end

	// interrupt status enhanced bits: writable when enabled, bit4 set by detect
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			isr_q <= 8'h00;
		end else begin
			if (regWr && regAddr == ADDR_INT_STATUS && efr_q[EF_ENH])
				isr_q <= regWdata & MASK_IS_ENH;
			if (specialHit) isr_q[4] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux, data one cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			// status runs carrier, ring, dsr, cts from the top bit down
			if (regAddr == ADDR_MODEM_STATUS) regRdata <= {stat[0], stat[1], stat[2], stat[3], delta_q};
			else if (regAddr == ADDR_SCRATCH) regRdata <= scratch_q;
			else if (regAddr == ADDR_DIV_LOW) regRdata <= divisor_q[7:0];
			else if (regAddr == ADDR_DIV_HIGH) regRdata <= divisor_q[15:8];
			// id and revision only valid with a zeroed divisor
			else if (regAddr == ADDR_PART_ID) regRdata <= (divisor_q == 16'h0000) ? PART_ID_VALUE : 8'h00;
			else if (regAddr == ADDR_PART_REV) regRdata <= (divisor_q == 16'h0000) ? PART_REV_VALUE : 8'h00;
			else if (regAddr == ADDR_ENH_FEATURE) regRdata <= efr_q;
			else if (regAddr == ADDR_MODEM_CONTROL) regRdata <= mcr_q;
			else if (regAddr == ADDR_INT_ENABLE) regRdata <= ier_q;
			else if (regAddr == ADDR_INT_STATUS) regRdata <= isr_q;
			else if (regAddr == ADDR_FIFO_CONTROL) regRdata <= fcr_q;
			else if (regAddr == ADDR_STOP_CHAR2) regRdata <= stop2_q;
			else if (regAddr == ADDR_RX_TRIGGER) regRdata <= {3'h0, rxTrig_q};
			else regRdata <= 8'h00; // unmapped reads zero
		end else begin
			regRdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// flow selection decode; software zeroes bits between settings
	always_comb begin
		case (efr_q[3:2])
			2'b10: txFlow = TXF_PAIR1;
			2'b01: txFlow = TXF_PAIR2;
			2'b11: txFlow = TXF_BOTH;
			default: txFlow = TXF_NONE;
		endcase
		case (efr_q[1:0])
			2'b10: rxFlow = RXF_PAIR1;
			2'b01: rxFlow = RXF_PAIR2;
			2'b11: rxFlow = (efr_q[3] ^ efr_q[2]) ? RXF_EITHER : RXF_SEQUENCE;
			default: rxFlow = RXF_NONE;
		endcase
	end

	// second pair send flag: raised when the transmit flow selects pair2 alone or both pairs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) txSendPair2 <= 1'b0;
		else txSendPair2 <= (txFlow == TXF_BOTH) || (txFlow == TXF_PAIR2);
	end

	////////////////////////////////////////////////////////////////
	// special character detect; the compare runs whatever the flow mode
	assign specialHit = efr_q[EF_SPECIAL] && rxValid && rxChar == stop2_q;
	assign dropMatch  = specialHit && rxFlow == RXF_PAIR2;

	// sequence tracker: in sequence mode the first char sets the flag and the next clears it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) seqHalf_q <= 1'b0;
		else if (rxValid) seqHalf_q <= (rxFlow == RXF_SEQUENCE) && !seqHalf_q;
	end

	// store strobe and interrupt pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxStore <= 1'b0;
			stopCharIrq <= 1'b0;
			specialIrq <= 1'b0;
		end else begin
			rxStore <= rxValid && !dropMatch;
			stopCharIrq <= dropMatch;
			specialIrq <= specialHit && ier_q[IE_SPECIAL];
		end
	end

	////////////////////////////////////////////////////////////////
	// auto RTS hysteresis around trigger level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rtsHold_q <= 1'b0;
			rxTriggerIrq <= 1'b0;
		end else begin
			rxTriggerIrq <= efr_q[EF_AUTO_RTS] && rxFill >= rxTrig_q;
			if (rxFill > rxTrig_q) rtsHold_q <= 1'b1;
			else if (rxFill < rxTrig_q) rtsHold_q <= 1'b0;
		end
	end

	// RTS and DTR pins, active low; control bit must be set for auto to act
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rtsN <= 1'b1;
			dtrN <= 1'b1;
		end else begin
			rtsN <= !(mcr_q[MC_RTS] && !(efr_q[EF_AUTO_RTS] && rtsHold_q));
			dtrN <= !mcr_q[MC_DTR];
		end
	end

	// auto CTS: pause only at character boundary
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txPause_q <= 1'b0;
			txAllowed <= 1'b1;
		end else begin
			if (!efr_q[EF_AUTO_CTS] || stat[3]) txPause_q <= 1'b0;
			else if (txCharDone) txPause_q <= 1'b1;
			txAllowed <= !(efr_q[EF_AUTO_CTS] && !stat[3] && (txPause_q || txCharDone));
		end
	end

	////////////////////////////////////////////////////////////////
	// baud tick: prescale, divide by 16, then by divisor
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= 2'h0;
			over_q <= 4'h0;
			baudCnt_q <= 16'h0000;
			baudTick <= 1'b0;
		end else begin
			baudTick <= 1'b0;
			if (pre_q == PRESCALE_LAST || !mcr_q[7]) begin
				pre_q <= 2'h0;
				over_q <= over_q + 4'h1;
				if (over_q == OVERSAMPLE_LAST) begin
					if (baudCnt_q + 16'h1 >= divisor_q) begin
						baudCnt_q <= 16'h0000;
						baudTick <= divisor_q != 16'h0000;
					end else begin
						baudCnt_q <= baudCnt_q + 16'h1;
					end
				end
			end else begin
				pre_q <= pre_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	AST_SCRATCH_RW: assert property (@(posedge clk) disable iff (!rstn)
		regWr && regAddr == ADDR_SCRATCH |=> scratch_q == $past(regWdata)) else $error("scratch not written");
	AST_LOOP_CTS: assert property (@(posedge clk) disable iff (!rstn)
		mcr_q[MC_LOOP] |-> stat[3] == mcr_q[MC_RTS]) else $error("loopback cts wrong");
	AST_READ_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == ADDR_MODEM_STATUS && stat == prev_q |=> delta_q == 4'h0) else $error("delta not cleared");
	AST_CD_DELTA: assert property (@(posedge clk) disable iff (!rstn)
		stat[0] != prev_q[0] |=> delta_q[3]) else $error("cd delta missed");
	AST_GATE: assert property (@(posedge clk) disable iff (!rstn)
		regWr && regAddr == ADDR_INT_ENABLE && !efr_q[EF_ENH] |=> ier_q[7:4] == $past(ier_q[7:4])) else $error("gated bits changed");
	AST_ID: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == ADDR_PART_ID && divisor_q == 16'h0000 |=> regRdata == PART_ID_VALUE) else $error("id wrong");
	AST_DROP: assert property (@(posedge clk) disable iff (!rstn)
		dropMatch |=> !rxStore && stopCharIrq) else $error("pair2 match stored");
	AST_RTS_GPO: assert property (@(posedge clk) disable iff (!rstn)
		!efr_q[EF_AUTO_RTS] ##1 !efr_q[EF_AUTO_RTS] |-> rtsN == !$past(mcr_q[MC_RTS])) else $error("rts not gpo");
	COV_LOOP: cover property (@(posedge clk) mcr_q[MC_LOOP] ##1 regRd);
	COV_SPECIAL: cover property (@(posedge clk) specialHit);
	COV_RTS: cover property (@(posedge clk) rtsHold_q && efr_q[EF_AUTO_RTS]);
	COV_PAIR2_DROP: cover property (@(posedge clk) dropMatch);
	COV_CTS_PAUSE: cover property (@(posedge clk) txPause_q && !txAllowed);

	// status mapping and delta flags
	AST_RI_DELTA: assert property (@(posedge clk) disable iff (!rstn)
		prev_q[1] && !stat[1] |=> delta_q[2]) else $error("ring delta missed");
	AST_LOOP_MAP: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == ADDR_MODEM_STATUS && mcr_q[MC_LOOP] |=> regRdata[7:4] ==
		{$past(mcr_q[MC_OUT2]), $past(mcr_q[MC_OUT1]), $past(mcr_q[MC_DTR]), $past(mcr_q[MC_RTS])})
		else $error("loopback status order wrong");
	AST_PIN_MAP: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == ADDR_MODEM_STATUS && !mcr_q[MC_LOOP] |=> regRdata[7:4] ==
		{!$past(sync2_q[0]), !$past(sync2_q[1]), !$past(sync2_q[2]), !$past(sync2_q[3])})
		else $error("pin status order wrong");
	// special characters and the sequence tracker
	AST_SPECIAL_ISR: assert property (@(posedge clk) disable iff (!rstn)
		specialHit |=> isr_q[4]) else $error("special status not set");
	AST_SEQ_OFF: assert property (@(posedge clk) disable iff (!rstn)
		rxValid && rxFlow != RXF_SEQUENCE |=> !seqHalf_q) else $error("sequence half outside sequence mode");
	AST_SEQ_FIRST: assert property (@(posedge clk) disable iff (!rstn)
		rxValid && rxFlow == RXF_SEQUENCE && !seqHalf_q |=> seqHalf_q) else $error("sequence first char lost");
	// hardware flow control
	AST_TX_PAUSE: assert property (@(posedge clk) disable iff (!rstn)
		efr_q[EF_AUTO_CTS] && !stat[3] && txCharDone |=> !txAllowed) else $error("transmit not paused");
	AST_RTS_AUTO: assert property (@(posedge clk) disable iff (!rstn)
		efr_q[EF_AUTO_RTS] && rtsHold_q |=> rtsN) else $error("rts not withdrawn");
	AST_TRIG_IRQ: assert property (@(posedge clk) disable iff (!rstn)
		efr_q[EF_AUTO_RTS] && rxFill >= rxTrig_q |=> rxTriggerIrq) else $error("trigger irq missed");
	// identification and baud generator
	AST_REV: assert property (@(posedge clk) disable iff (!rstn)
		regRd && regAddr == ADDR_PART_REV && divisor_q == 16'h0000 |=> regRdata == PART_REV_VALUE) else $error("rev wrong");
	AST_NO_TICK: assert property (@(posedge clk) disable iff (!rstn)
		divisor_q == 16'h0000 |=> !baudTick) else $error("tick with zero divisor");
endmodule // umf_uart_modem
`default_nettype wire

/* File: tb/umf_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// remote modem on the line side: drives the active-low status pins
module umf_modem_model (
	// clock
	input  wire logic                   clk,
	// control pins from the block, watched only
	input  wire logic                   rtsN,
	input  wire logic                   dtrN,
	// status pins towards the block
	output var  umf_pkg::umf_modem_in_t modemPins
);
	import umf_pkg::*;
	// idle remote asserts nothing, so every pin rests high
	initial modemPins = 4'hf;
	// pins move only just after an edge, the block syncs them anyway
	task automatic setPins(input logic [3:0] v);
		@(posedge clk);
		modemPins <= v;
	endtask
	// a slow remote: withdraws clear-to-send for n cycles, then grants it again
	task automatic holdOff(input int n);
		setPins({1'b1, modemPins[2:0]});
		repeat (n) @(posedge clk);
		modemPins <= {1'b0, modemPins[2:0]};
	endtask
endmodule // umf_modem_model
`default_nettype wire

/* File: tb/umf_uart_modem_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module umf_uart_modem_bench;
	import umf_pkg::*;
	// clock, reset and register port
	logic          clk, rstn, regWr, regRd;
	logic [3:0]    regAddr;
	logic [7:0]    regWdata, regRdata, rxChar, rv;
	// pins and datapath handshakes
	umf_modem_in_t modemPins;
	logic          rtsN, dtrN, txCharDone, txAllowed, rxValid, rxStore, baudTick;
	logic          modemIrq, specialIrq, stopCharIrq, rxTriggerIrq, txSendPair2;
	logic [4:0]    rxFill;
	logic [2:0]    seen;     // store, stop, special seen after one character
	int            failures, checked;
	////////////////////////////////////////////////////////////
	umf_uart_modem umf_uart_modem_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .modemPins(modemPins), .rtsN(rtsN), .dtrN(dtrN),
		.txCharDone(txCharDone), .txAllowed(txAllowed), .rxValid(rxValid), .rxChar(rxChar), .rxFill(rxFill),
		.rxStore(rxStore), .baudTick(baudTick), .modemIrq(modemIrq), .specialIrq(specialIrq),
		.stopCharIrq(stopCharIrq), .rxTriggerIrq(rxTriggerIrq), .txSendPair2(txSendPair2));
	umf_modem_model umf_modem_model_inst (.clk(clk), .rtsN(rtsN), .dtrN(dtrN), .modemPins(modemPins));
	////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// one compare for every kind of value, widened to 16 bits
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// register writes and reads, one strobe cycle each
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rv = regRdata;   // data stand only in the cycle after the strobe
		chk(what, {8'h00, exp}, {8'h00, rv});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// one received character, outputs gathered over a short window
	task automatic rxPulse(input logic [7:0] c);
		@(posedge clk);
		rxValid <= 1'b1;
		rxChar <= c;
		@(posedge clk);
		rxValid <= 1'b0;
		seen = 3'b000;
		repeat (4) begin
			@(negedge clk);
			seen = seen | {rxStore, stopCharIrq, specialIrq};
		end
	endtask
	// skip one tick, since a divisor change may cut a period short, then time the next
	task automatic tickGap(input int exp);
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (baudTick !== 1'b1 && n < 9000);
		n = 0;
		do begin @(negedge clk); n++; end while (baudTick !== 1'b1 && n < 9000);
		chk("baud tick gap", exp[15:0], n[15:0]);
	endtask
	////////////////////////////////////////////////////////////
	task automatic test_reset;
		rdChk("scratch reset", ADDR_SCRATCH, SCRATCH_RESET);
		rdChk("status at idle", ADDR_MODEM_STATUS, 8'h00);
		rdChk("int enable reset", ADDR_INT_ENABLE, 8'h00);
		rdChk("modem control reset", ADDR_MODEM_CONTROL, 8'h00);
		rdChk("divisor low reset", ADDR_DIV_LOW, DIVISOR_RESET[7:0]);
		chk("rts idle", 16'h1, {15'h0, rtsN});
		chk("dtr idle", 16'h1, {15'h0, dtrN});
		chk("tx allowed, auto off", 16'h1, {15'h0, txAllowed});
		wr(ADDR_SCRATCH, 8'ha5);
		rdChk("scratch rw", ADDR_SCRATCH, 8'ha5);
	endtask
	task automatic test_pins;
		umf_modem_model_inst.setPins(4'b0110);
		cyc(5);
		rdChk("status cts cd", ADDR_MODEM_STATUS, 8'h99);
		rdChk("deltas cleared", ADDR_MODEM_STATUS, 8'h90);
		umf_modem_model_inst.setPins(4'b0100);     // ring pin falls: no delta
		cyc(5);
		rdChk("ring start", ADDR_MODEM_STATUS, 8'hd0);
		wr(ADDR_INT_ENABLE, 8'h08);
		umf_modem_model_inst.setPins(4'b0110);     // ring pin rises: ringing ends
		cyc(6);
		chk("modem irq", 16'h1, {15'h0, modemIrq});
		rdChk("ring end delta", ADDR_MODEM_STATUS, 8'h94);
		cyc(3);
		chk("modem irq after read", 16'h0, {15'h0, modemIrq});
		umf_modem_model_inst.setPins(4'b0111);
		cyc(5);
		rdChk("carrier drop delta", ADDR_MODEM_STATUS, 8'h18);
	endtask
	task automatic test_loop;
		wr(ADDR_ENH_FEATURE, 8'h10);
		wr(ADDR_MODEM_CONTROL, 8'h15);
		cyc(5);
		// entering loopback drops cts and raises dsr: two deltas, ring rising gives none
		rdChk("loop dtr ring", ADDR_MODEM_STATUS, 8'h63);
		chk("loop upper a", 16'h6, {12'h0, rv[7:4]});
		wr(ADDR_MODEM_CONTROL, 8'h1a);
		cyc(5);
		// all four status bits flip, ring falling marks end of ring
		rdChk("loop rts carrier", ADDR_MODEM_STATUS, 8'h9f);
		chk("loop upper b", 16'h9, {12'h0, rv[7:4]});
		wr(ADDR_MODEM_CONTROL, 8'h00);
	endtask
	task automatic test_gate;
		wr(ADDR_ENH_FEATURE, 8'h00);
		wr(ADDR_INT_ENABLE, 8'hff);
		rdChk("gated int enable", ADDR_INT_ENABLE, 8'h0f);
		wr(ADDR_MODEM_CONTROL, 8'hff);
		rdChk("gated modem control", ADDR_MODEM_CONTROL, 8'h1b);
		wr(ADDR_ENH_FEATURE, 8'h10);
		wr(ADDR_INT_ENABLE, 8'hff);
		rdChk("open int enable", ADDR_INT_ENABLE, 8'hff);
		wr(ADDR_ENH_FEATURE, 8'h00);
		wr(ADDR_INT_ENABLE, 8'h00);
		rdChk("latched int enable", ADDR_INT_ENABLE, 8'hf0);
		wr(ADDR_ENH_FEATURE, 8'h10);
		wr(ADDR_INT_ENABLE, 8'h20);
		wr(ADDR_MODEM_CONTROL, 8'h00);
	endtask
	task automatic test_div;
		rdChk("id hidden", ADDR_PART_ID, 8'h00);
		wr(ADDR_DIV_LOW, 8'h00);
		wr(ADDR_DIV_HIGH, 8'h00);
		wr(ADDR_PART_ID, 8'h00);
		rdChk("part id", ADDR_PART_ID, PART_ID_VALUE);
		rdChk("part rev", ADDR_PART_REV, PART_REV_VALUE);
		wr(ADDR_DIV_LOW, 8'h02);
		tickGap(32);
		wr(ADDR_DIV_LOW, 8'h00);
		wr(ADDR_DIV_HIGH, 8'h01);
		tickGap(4096);
		// divide-by-four prescaler with the smallest divisor
		wr(ADDR_DIV_HIGH, 8'h00);
		wr(ADDR_DIV_LOW, 8'h01);
		wr(ADDR_MODEM_CONTROL, 8'h80);
		tickGap(64);
		wr(ADDR_MODEM_CONTROL, 8'h00);
	endtask
	task automatic test_rts;
		wr(ADDR_MODEM_CONTROL, 8'h03);
		rxFill <= 5'd20;
		cyc(4);
		chk("rts general output", 16'h0, {15'h0, rtsN});
		chk("dtr general output", 16'h0, {15'h0, dtrN});
		// empty the fifo first so the throttle starts released
		@(posedge clk) rxFill <= 5'd0;
		wr(ADDR_ENH_FEATURE, 8'h50);
		rxFill <= 5'd8;
		cyc(4);
		chk("trigger irq", 16'h1, {15'h0, rxTriggerIrq});
		chk("rts at trigger", 16'h0, {15'h0, rtsN});
		@(posedge clk) rxFill <= 5'd9;
		cyc(4);
		chk("rts above trigger", 16'h1, {15'h0, rtsN});
		@(posedge clk) rxFill <= 5'd8;
		cyc(4);
		chk("rts held", 16'h1, {15'h0, rtsN});
		@(posedge clk) rxFill <= 5'd6;
		cyc(4);
		chk("rts released", 16'h0, {15'h0, rtsN});
		chk("trigger irq below", 16'h0, {15'h0, rxTriggerIrq});
	endtask
	task automatic test_cts;
		wr(ADDR_ENH_FEATURE, 8'h90);
		umf_modem_model_inst.setPins(4'b0111);
		fork
			umf_modem_model_inst.holdOff(40);
			begin
				cyc(8);
				@(posedge clk) txCharDone <= 1'b1;
				@(posedge clk) txCharDone <= 1'b0;
				cyc(4);
				chk("tx stopped", 16'h0, {15'h0, txAllowed});
			end
		join
		cyc(6);
		chk("tx resumed", 16'h1, {15'h0, txAllowed});
	endtask
	task automatic test_special;
		wr(ADDR_STOP_CHAR2, 8'h13);
		wr(ADDR_ENH_FEATURE, 8'h30);
		rxPulse(8'h13);
		chk("match stored", 16'h4, {13'h0, seen & 3'b110});
		rdChk("special status bit", ADDR_INT_STATUS, 8'h10);
		wr(ADDR_INT_STATUS, 8'h00);
		rdChk("special status cleared", ADDR_INT_STATUS, 8'h00);
		wr(ADDR_ENH_FEATURE, 8'h31);
		rxPulse(8'h13);
		chk("pair2 match held back", 16'h3, {13'h0, seen});
		rxPulse(8'hec);
		chk("other char stored", 16'h4, {13'h0, seen});
		wr(ADDR_ENH_FEATURE, 8'h30);
		wr(ADDR_ENH_FEATURE, 8'h32);
		rxPulse(8'h13);
		chk("pair1 match stored", 16'h1, {15'h0, seen[2]});
		// both receive pairs: in sequence with no transmit flow, either with pair1 sent
		wr(ADDR_ENH_FEATURE, 8'h30);
		wr(ADDR_ENH_FEATURE, 8'h33);
		rxPulse(8'h11);
		rxPulse(8'h13);
		chk("sequence match stored", 16'h4, {13'h0, seen & 3'b110});
		wr(ADDR_ENH_FEATURE, 8'h30);
		wr(ADDR_ENH_FEATURE, 8'h3b);
		rxPulse(8'h13);
		chk("either pair match stored", 16'h4, {13'h0, seen & 3'b110});
		// every transmit selection, flow bits cleared before each
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_ENH_FEATURE, 8'h10);
			wr(ADDR_ENH_FEATURE, 8'h10 | 8'(i << 2));
			cyc(3);
			chk("second pair send", {15'h0, i[0]}, {15'h0, txSendPair2});
		end
	endtask
	////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under 20k cycles
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_sim;
	end
	// main sequence
	initial begin
		failures = 0;
		checked = 0;
		rstn = 1'b0;
		{regWr, regRd, txCharDone, rxValid} = 4'h0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		rxChar = 8'h00;
		rxFill = 5'd0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		test_reset;
		test_pins;
		test_loop;
		test_gate;
		test_div;
		test_rts;
		test_cts;
		test_special;
		end_sim;
	end
endmodule // umf_uart_modem_bench
`default_nettype wire
